// File: dv/pci_target_read_dword_steering_tb.sv
// self-checking bench: far end reads through the target end
`include "pts_regs.svh"
module pci_target_read_dword_steering_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 4; // small memory so index wrap comes up often
    // design inputs, all set at time zero
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_start = 1'b0;
    logic [`PTS_AD_W-1:0] i_addr = '0;
    logic [`PTS_CBE_W-1:0] i_cmd = '0;
    logic i_mem_we = 1'b0;
    logic [1:0] i_mem_idx = '0;
    logic [`PTS_LD_W-1:0] i_mem_wdata = '0;
    // design outputs
    logic t_busy, f_busy, f_valid, f_done;
    logic [`PTS_NBAR-1:0] last_hit;
    logic [`PTS_AD_W-1:0] f_data;
    // bench state
    logic [`PTS_LD_W-1:0] mem [DEPTH]; // bench copy of back-end memory
    logic [`PTS_AD_W-1:0] rdq [$]; // dwords seen by the far end
    logic [3:0] cmds [3] = '{`PTS_CMD_MEM_RD, `PTS_CMD_MEM_RD_MULT, `PTS_CMD_MEM_RD_LINE};
    logic [`PTS_AD_W-1:0] a;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 32'h19442f20;

    pts_if i_pts_if ();
    pts_target_end i_pts_target_end (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .bus(i_pts_if.tgt), .o_busy(t_busy),
        .o_last_hit(last_hit));
    pts_far_end #(.MEM_DEPTH(DEPTH)) i_pts_far_end (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .bus(i_pts_if.far), .i_start(i_start),
        .i_addr(i_addr), .i_cmd(i_cmd), .o_busy(f_busy), .o_rd_data(f_data),
        .o_rd_valid(f_valid), .o_done(f_done), .i_mem_we(i_mem_we), .i_mem_idx(i_mem_idx),
        .i_mem_wdata(i_mem_wdata));
    pts_monitor i_pts_monitor (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .ad(i_pts_if.ad), .frame_n(i_pts_if.frame_n),
        .irdy_n(i_pts_if.irdy_n), .trdy_n(i_pts_if.trdy_n), .devsel_n(i_pts_if.devsel_n),
        .ad_t_oe(i_pts_if.ad_t_oe), .tctl_oe(i_pts_if.tctl_oe),
        .local_addr_out(i_pts_if.local_addr_out), .bar_hit(i_pts_if.bar_hit),
        .local_ready_n(i_pts_if.local_ready_n), .low_half_xfer_n(i_pts_if.low_half_xfer_n),
        .high_half_xfer_n(i_pts_if.high_half_xfer_n));

    // 250 mhz clock
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    // capture on the falling edge, away from the register updates
    always @(negedge i_clk) begin
        if (f_valid === 1'b1) begin
            rdq.push_back(f_data);
        end
    end
    // hang guard: a read takes about 8 cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            wrap_up();
        end
    end

    // counts, verdict, end of run
    task automatic wrap_up();
        $display("compares %0d errors %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // dword k of a burst: alignment picks the half, odd start moves on a qword
    function automatic logic [31:0] exp_dw(input logic [31:0] adr, input int k);
        logic [1:0] q;
        q = adr[4:3] + 2'(adr[2] & k[0]);
        if (adr[2] ^ k[0]) begin
            return mem[q][63:32];
        end
        return mem[q][31:0];
    endfunction
    // async reset held four cycles
    task automatic rst();
        i_arst_n = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 i_arst_n = 1'b1;
    endtask
    // one-cycle start pulse once the master is idle
    task automatic start(input logic [31:0] adr, input logic [3:0] cmd);
        for (int n = 0; n < 20 && f_busy !== 1'b0; n++) begin
            @(posedge i_clk);
            #1;
        end
        i_start = 1'b1;
        i_addr = adr;
        i_cmd = cmd;
        @(posedge i_clk);
        #1 i_start = 1'b0;
    endtask
    // two-dword read and its checks
    task automatic do_read(input logic [31:0] adr, input logic [3:0] cmd);
        int n;
        rdq.delete();
        start(adr, cmd);
        n = 0;
        while (f_done !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        @(negedge i_clk);
        #1;
        chk(32'(rdq.size()), 32'd2);
        chk(rdq[0], exp_dw(adr, 0));
        chk(rdq[1], exp_dw(adr, 1));
        chk(32'(last_hit), 32'h1);
    endtask

    initial begin
        rst();
        @(posedge i_clk);
        #1;
        // idle after reset: no hit, strobes high, nothing driven
        a = {21'h0, i_pts_if.bar_hit, i_pts_if.low_half_xfer_n, i_pts_if.high_half_xfer_n,
             i_pts_if.tctl_oe, i_pts_if.ad_t_oe, t_busy};
        chk(a, 32'h18);
        // load back-end memory with random qwords
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = {$random(seed), $random(seed)};
            i_mem_we = 1'b1;
            i_mem_idx = 2'(i);
            i_mem_wdata = mem[i];
            @(posedge i_clk);
            #1;
        end
        i_mem_we = 1'b0;
        // last qword, both alignments, odd one wraps the index
        do_read(32'h1000_0018, `PTS_CMD_MEM_RD);
        do_read(32'h1000_001c, `PTS_CMD_MEM_RD);
        // random addresses, alternating alignment, every read command
        for (int i = 0; i < 12; i++) begin
            a = 32'h1000_0000 | (32'($random(seed)) & 32'h00ff_fff8) | 32'(i[0]) << 2;
            do_read(a, cmds[i % 3]);
        end
        // refused: outside the region, then a write; master hangs so reset
        for (int i = 0; i < 2; i++) begin
            start(i == 0 ? 32'h2000_0000 : 32'h1000_0000, i == 0 ? 4'h6 : 4'h7);
            repeat (10) @(posedge i_clk);
            #1;
            a = {29'h0, |i_pts_if.bar_hit, i_pts_if.devsel_n, t_busy};
            chk(a, 32'h2);
            rst();
            // reset in mid transfer: target back to its idle image
            a = {21'h0, i_pts_if.bar_hit, i_pts_if.low_half_xfer_n, i_pts_if.high_half_xfer_n,
                 i_pts_if.tctl_oe, i_pts_if.ad_t_oe, t_busy};
            chk(a, 32'h18);
        end
        // recovery after the mid-run reset
        do_read(32'h1000_0004, `PTS_CMD_MEM_RD_LINE);
        wrap_up();
    end
endmodule

// File: dv/pts_monitor.sv
// concurrent checks on the pci and local wires between both ends
`include "pts_regs.svh"
module pts_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // pci wires
    input wire logic [`PTS_AD_W-1:0] ad,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    input wire logic devsel_n,
    input wire logic ad_t_oe,
    input wire logic tctl_oe,
    // local bus
    input wire logic [`PTS_AD_W-1:0] local_addr_out,
    input wire logic [`PTS_NBAR-1:0] bar_hit,
    input wire logic local_ready_n,
    input wire logic low_half_xfer_n,
    input wire logic high_half_xfer_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset given once
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // hit only on claimed reads, so a refused address never trips these
    chk_addr_local: assert property (
        $rose(|bar_hit) |-> local_addr_out == $past(ad, 2))
        else $error("local address not the captured one");
    chk_hit_cycle: assert property (
        $rose(|bar_hit) |-> !$past(frame_n, 2) && $past(frame_n, 3))
        else $error("hit not two cycles after address");
    chk_slow_select: assert property (
        $rose(|bar_hit) |=> !devsel_n && trdy_n)
        else $error("select not one cycle after hit");
    chk_low_first: assert property (
        $fell(local_ready_n) && !local_addr_out[2] |=> !low_half_xfer_n && high_half_xfer_n)
        else $error("aligned start without low strobe");
    chk_high_first: assert property (
        $fell(local_ready_n) && local_addr_out[2] |=> !high_half_xfer_n && low_half_xfer_n)
        else $error("odd start without high strobe");
    chk_trdy_data: assert property (
        $fell(trdy_n) |-> ad_t_oe && !devsel_n)
        else $error("ready without data driven");
    chk_aligned_next: assert property (
        !low_half_xfer_n && !local_addr_out[2] && !irdy_n |=> !high_half_xfer_n && low_half_xfer_n)
        else $error("aligned second strobe missing");
    chk_odd_ready: assert property (
        $fell(trdy_n) && local_addr_out[2] |-> !$past(local_ready_n) && !$past(local_ready_n, 2))
        else $error("odd start ready too early");
    chk_odd_next: assert property (
        !high_half_xfer_n && local_addr_out[2] && !irdy_n && !local_ready_n |=> !low_half_xfer_n)
        else $error("odd second strobe missing");
    chk_second_phase: assert property (
        !trdy_n && !irdy_n && !frame_n |=> !trdy_n && ad_t_oe)
        else $error("ready dropped before last phase");
    chk_turn_release: assert property (
        !trdy_n && !irdy_n && frame_n |=> trdy_n && devsel_n && !ad_t_oe)
        else $error("target still drives after last phase");
    chk_idle_clear: assert property (
        !trdy_n && !irdy_n && frame_n |=> ##1 !tctl_oe && bar_hit == '0
            && low_half_xfer_n && high_half_xfer_n)
        else $error("idle cycle not clean");
endmodule

// File: rtl/pts_dword_steer.sv
// picks one dword out of a local qword
`include "pts_regs.svh"
module pts_dword_steer #(
    parameter int W = `PTS_AD_W
) (
    // qword and half select
    input wire logic [2*W-1:0] i_qword,
    input wire logic i_upper,
    // chosen dword
    output logic [W-1:0] o_dword
);
    // plain mux, registered by the caller
    assign o_dword = i_upper ? i_qword[2*W-1:W] : i_qword[W-1:0];
endmodule

// File: rtl/pts_far_end.sv
// far end: pci read master plus a qword memory back-end
`include "pts_regs.svh"
module pts_far_end import pts_pkg::*; #(
    parameter int MEM_DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // pci pins and local bus
    pts_if.far bus,
    // read request
    input wire logic i_start,
    input wire logic [`PTS_AD_W-1:0] i_addr,
    input wire logic [`PTS_CBE_W-1:0] i_cmd,
    // read result
    output logic o_busy,
    output logic [`PTS_AD_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_done,
    // back-end memory load
    input wire logic i_mem_we,
    input wire logic [$clog2(MEM_DEPTH)-1:0] i_mem_idx,
    input wire logic [`PTS_LD_W-1:0] i_mem_wdata
);
    localparam int AW = $clog2(MEM_DEPTH);

    // whole far end state
    typedef struct packed {
        pts_mst_state_t state;
        logic [`PTS_AD_W-1:0] ad;
        logic ad_oe;
        logic [`PTS_CBE_W-1:0] cbe;
        logic cbe_oe;
        logic frame_n;
        logic frame_oe;
        logic irdy_n;
        logic irdy_oe;
        logic beat;
        logic [`PTS_AD_W-1:0] rdata;
        logic rvalid;
        logic done;
        logic ready_n;
        logic hit_prev;
        logic [AW-1:0] qptr;
        logic [`PTS_LD_W-1:0] ldata;
    } pts_far_st_t;

    localparam pts_far_st_t FAR_RST = '{
        state: M_IDLE, ad: `PTS_AD_RST, ad_oe: 1'b0, cbe: `PTS_CBE_W'(0),
        cbe_oe: 1'b0, frame_n: 1'b1, frame_oe: 1'b0, irdy_n: 1'b1,
        irdy_oe: 1'b0, beat: 1'b0, rdata: `PTS_AD_RST, rvalid: 1'b0,
        done: 1'b0, ready_n: 1'b1, hit_prev: 1'b0, qptr: AW'(0),
        ldata: `PTS_LD_RST
    };

    pts_far_st_t r;                              // registered state
    pts_far_st_t n;                              // next state
    logic [`PTS_LD_W-1:0] mem [MEM_DEPTH];       // back-end qword store

    // master and back-end sequencing
    always_comb begin
        n = r;
        n.rvalid = 1'b0;
        n.done = 1'b0;
        case (r.state)
            M_IDLE: begin
                n.irdy_oe = 1'b0;
                if (i_start) begin
                    // address cycle next
                    n.ad = i_addr;
                    n.ad_oe = 1'b1;
                    n.cbe = i_cmd;
                    n.cbe_oe = 1'b1;
                    n.frame_n = 1'b0;
                    n.frame_oe = 1'b1;
                    n.irdy_n = 1'b1;
                    n.irdy_oe = 1'b1;
                    n.beat = 1'b0;
                    n.state = M_ADDR;
                end
            end
            M_ADDR: begin
                // turnaround: float ad, enables on, ready for data
                n.ad_oe = 1'b0;
                n.cbe = `PTS_BE_ALL;
                n.irdy_n = 1'b0;
                n.state = M_DATA;
            end
            M_DATA: begin
                // no master abort: a miss leaves the master waiting
                if (!bus.trdy_n && !r.irdy_n) begin
                    n.rvalid = 1'b1;
                    n.rdata = bus.ad;
                    if (!r.beat) begin
                        n.beat = 1'b1;
                        n.frame_n = 1'b1;
                    end else begin
                        n.irdy_n = 1'b1;
                        n.frame_oe = 1'b0;
                        n.cbe_oe = 1'b0;
                        n.done = 1'b1;
                        n.state = M_TA;
                    end
                end
            end
            M_TA: begin
                n.irdy_oe = 1'b0;
                n.state = M_IDLE;
            end
            default: begin
                n.state = M_IDLE;
            end
        endcase
        // back-end: ready and qword data both one cycle after the hit
        n.hit_prev = |bus.bar_hit;
        n.ready_n = !(|bus.bar_hit);
        if ((|bus.bar_hit) && !r.hit_prev) begin
            n.qptr = bus.local_addr_out[`PTS_QW_LSB +: AW];
        end else if (!bus.high_half_xfer_n) begin
            // upper half taken: move to the next qword
            n.qptr = AW'(r.qptr + 1'b1);
        end
        n.ldata = mem[n.qptr];
    end

    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= FAR_RST;
        end else begin
            r <= n;
        end
    end

    // memory write port, no reset on storage
    always_ff @(posedge i_clk) begin
        if (i_mem_we) begin
            mem[i_mem_idx] <= i_mem_wdata;
        end
    end

    // pins and user side
    assign bus.ad_m = r.ad;
    assign bus.ad_m_oe = r.ad_oe;
    assign bus.cbe_m = r.cbe;
    assign bus.cbe_m_oe = r.cbe_oe;
    assign bus.frame_n_m = r.frame_n;
    assign bus.frame_m_oe = r.frame_oe;
    assign bus.irdy_n_m = r.irdy_n;
    assign bus.irdy_m_oe = r.irdy_oe;
    assign bus.local_ready_n = r.ready_n;
    assign bus.local_data_in = r.ldata;
    assign o_busy = r.state != M_IDLE;
    assign o_rd_data = r.rdata;
    assign o_rd_valid = r.rvalid;
    assign o_done = r.done;
endmodule

// File: rtl/pts_if.sv
// pci pins and local back-end bus between target end and far end
`include "pts_regs.svh"
interface pts_if;
    // resolved pci wires
    logic [`PTS_AD_W-1:0] ad;
    logic [`PTS_CBE_W-1:0] cbe_n;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    // master drives
    logic [`PTS_AD_W-1:0] ad_m;
    logic ad_m_oe;
    logic [`PTS_CBE_W-1:0] cbe_m;
    logic cbe_m_oe;
    logic frame_n_m;
    logic frame_m_oe;
    logic irdy_n_m;
    logic irdy_m_oe;
    // target drives
    logic [`PTS_AD_W-1:0] ad_t;
    logic ad_t_oe;
    logic trdy_n_t;
    logic devsel_n_t;
    logic tctl_oe;
    // local back-end bus
    logic [`PTS_AD_W-1:0] local_addr_out;
    logic [`PTS_NBAR-1:0] bar_hit;
    logic local_ready_n;
    logic [`PTS_LD_W-1:0] local_data_in;
    logic low_half_xfer_n;
    logic high_half_xfer_n;

    // undriven pci wires float high through the pull-ups
    assign ad = ad_t_oe ? ad_t : (ad_m_oe ? ad_m : '1);
    assign cbe_n = cbe_m_oe ? cbe_m : '1;
    assign frame_n = frame_m_oe ? frame_n_m : 1'b1;
    assign irdy_n = irdy_m_oe ? irdy_n_m : 1'b1;
    assign trdy_n = tctl_oe ? trdy_n_t : 1'b1;
    assign devsel_n = tctl_oe ? devsel_n_t : 1'b1;

    modport tgt (
        input ad, cbe_n, frame_n, irdy_n, local_ready_n, local_data_in,
        output ad_t, ad_t_oe, trdy_n_t, devsel_n_t, tctl_oe,
        output local_addr_out, bar_hit, low_half_xfer_n, high_half_xfer_n
    );
    modport far (
        input ad, trdy_n, devsel_n,
        input local_addr_out, bar_hit, low_half_xfer_n, high_half_xfer_n,
        output ad_m, ad_m_oe, cbe_m, cbe_m_oe, frame_n_m, frame_m_oe,
        output irdy_n_m, irdy_m_oe, local_ready_n, local_data_in
    );
endinterface

// File: rtl/pts_pkg.sv
// types shared by the read-path target and its far end
`include "pts_regs.svh"
package pts_pkg;
    // target sequencer states, one per bus cycle kind
    typedef enum logic [2:0] {
        T_IDLE,
        T_DECODE,
        T_HIT,
        T_WAIT_RDY,
        T_FETCH1,
        T_DATA1,
        T_DATA2,
        T_TURN
    } pts_tgt_state_t;

    // far end master states
    typedef enum logic [1:0] {
        M_IDLE,
        M_ADDR,
        M_DATA,
        M_TA
    } pts_mst_state_t;

    // whole state of the target end
    typedef struct packed {
        pts_tgt_state_t state;
        logic frame_prev;
        logic [`PTS_AD_W-1:0] addr;
        logic [`PTS_CBE_W-1:0] cmd;
        logic qw;
        logic [`PTS_NBAR-1:0] bar_hit;
        logic devsel_n;
        logic trdy_n;
        logic ctl_oe;
        logic ad_oe;
        logic [`PTS_AD_W-1:0] ad;
        logic [`PTS_AD_W-1:0] hold;
        logic lo_n;
        logic hi_n;
        logic pend;
        logic [`PTS_NBAR-1:0] last_hit;
    } pts_tgt_st_t;
endpackage

// File: rtl/pts_regs.svh
// constants shared by the read-path target, its far end and the interface
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH
`define PTS_AD_W 32
`define PTS_LD_W 64
`define PTS_CBE_W 4
`define PTS_NBAR 6
`define PTS_QW_BIT 2
`define PTS_QW_LSB 3
`define PTS_CMD_MEM_RD 4'h6
`define PTS_CMD_MEM_RD_MULT 4'hc
`define PTS_CMD_MEM_RD_LINE 4'he
`define PTS_BE_ALL 4'h0
`define PTS_BAR_HIT_RST 6'h00
`define PTS_AD_RST 32'h0000_0000
`define PTS_LD_RST 64'h0000_0000_0000_0000
`endif

// File: rtl/pts_target_end.sv
// pci target read path with dword steering from a 64-bit local bus
`include "pts_regs.svh"
module pts_target_end import pts_pkg::*; #(
    parameter logic [`PTS_NBAR-1:0] BAR_EN = 6'h01,
    parameter logic [`PTS_NBAR*32-1:0] BAR_BASE = {6{32'h1000_0000}},
    parameter logic [`PTS_NBAR*32-1:0] BAR_MASK = {6{32'hff00_0000}}
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // pci pins and local bus
    pts_if.tgt bus,
    // user side status
    output logic o_busy,
    output logic [`PTS_NBAR-1:0] o_last_hit
);
    // reset image of all state
    localparam pts_tgt_st_t TGT_RST = '{
        state: T_IDLE,
        frame_prev: 1'b1,
        addr: `PTS_AD_RST,
        cmd: `PTS_CBE_W'(0),
        qw: 1'b1,
        bar_hit: `PTS_BAR_HIT_RST,
        devsel_n: 1'b1,
        trdy_n: 1'b1,
        ctl_oe: 1'b0,
        ad_oe: 1'b0,
        ad: `PTS_AD_RST,
        hold: `PTS_AD_RST,
        lo_n: 1'b1,
        hi_n: 1'b1,
        pend: 1'b0,
        last_hit: `PTS_BAR_HIT_RST
    };

    pts_tgt_st_t r;                     // registered state
    pts_tgt_st_t n;                     // next state
    logic [`PTS_NBAR-1:0] hit;          // per region address match
    logic [`PTS_AD_W-1:0] dword;        // steered local dword
    logic fetch_now;                    // a half strobe is active this cycle
    logic cond2;                        // second half may be requested
    logic fire2;                        // request the second half now

    // masked compare of an address against one region
    function automatic logic region_match(input logic [31:0] a, input logic [31:0] b,
                                          input logic [31:0] m);
        return (a & m) == (b & m);
    endfunction

    // only the memory read family is claimed
    function automatic logic is_read_cmd(input logic [`PTS_CBE_W-1:0] c);
        return c == `PTS_CMD_MEM_RD || c == `PTS_CMD_MEM_RD_MULT ||
               c == `PTS_CMD_MEM_RD_LINE;
    endfunction

    // strobe pair {low, high}, active low, for the wanted half
    function automatic logic [1:0] half_strobe(input logic upper);
        return upper ? 2'b10 : 2'b01;
    endfunction

    // region decode on the captured address
    genvar g;
    generate
        for (g = 0; g < `PTS_NBAR; g++) begin : g_bar
            assign hit[g] = BAR_EN[g] &&
                region_match(r.addr, BAR_BASE[g*32 +: 32], BAR_MASK[g*32 +: 32]);
        end
    endgenerate

    // the active strobe names the half on the local data lines
    assign fetch_now = !r.lo_n || !r.hi_n;

    pts_dword_steer #(
        .W(`PTS_AD_W)
    ) u_steer (
        .i_qword(bus.local_data_in),
        .i_upper(!r.hi_n),
        .o_dword(dword)
    );

    // aligned start waits only on irdy, odd start also on ready
    assign cond2 = r.qw ? !bus.irdy_n : (!bus.irdy_n && !bus.local_ready_n);

    // sequencer: one state per pci clock of the read
    always_comb begin
        n = r;
        fire2 = 1'b0;
        n.frame_prev = bus.frame_n;
        // strobes are one-cycle pulses unless set below
        n.lo_n = 1'b1;
        n.hi_n = 1'b1;
        case (r.state)
            T_IDLE: begin
                // catch the address cycle on the falling frame only
                if (!bus.frame_n && r.frame_prev) begin
                    n.addr = bus.ad;
                    n.cmd = bus.cbe_n;
                    n.qw = !bus.ad[`PTS_QW_BIT];
                    n.state = T_DECODE;
                end
            end
            T_DECODE: begin
                // turnaround cycle: address is on the local bus now
                if (is_read_cmd(r.cmd) && (|hit)) begin
                    n.bar_hit = hit;
                    n.last_hit = hit;
                    n.state = T_HIT;
                end else begin
                    n.state = T_IDLE;
                end
            end
            T_HIT: begin
                // slow select timing: devsel one clock after the hit
                n.devsel_n = 1'b0;
                n.trdy_n = 1'b1;
                n.ctl_oe = 1'b1;
                n.state = T_WAIT_RDY;
            end
            T_WAIT_RDY: begin
                // ready seen: ask for the half that holds the first dword
                if (!bus.local_ready_n) begin
                    {n.lo_n, n.hi_n} = half_strobe(!r.qw);
                    n.state = T_FETCH1;
                end
            end
            T_FETCH1: begin
                // capture only while a strobe marks valid local data
                if (fetch_now) begin
                    n.ad = dword;
                end
                // odd start needs ready for two cycles in a row
                if (r.qw || !bus.local_ready_n) begin
                    n.trdy_n = 1'b0;
                    n.ad_oe = 1'b1;
                    n.pend = 1'b1;
                    n.state = T_DATA1;
                    fire2 = cond2;
                end
            end
            T_DATA1: begin
                fire2 = r.pend && cond2;
                if (fetch_now) begin
                    n.hold = dword;
                end
                if (!bus.irdy_n) begin
                    if (bus.frame_n) begin
                        // single phase: end without the second half
                        fire2 = 1'b0;
                        n.state = T_TURN;
                        n.ad_oe = 1'b0;
                        n.devsel_n = 1'b1;
                        n.trdy_n = 1'b1;
                        n.pend = 1'b0;
                    end else begin
                        n.state = T_DATA2;
                        if (fetch_now) begin
                            n.ad = dword;
                        end else if (!r.pend) begin
                            n.ad = r.hold;
                        end else begin
                            // second half not fetched yet: wait state
                            n.trdy_n = 1'b1;
                        end
                    end
                end
            end
            T_DATA2: begin
                if (r.trdy_n) begin
                    // late second half: issue and capture, then trdy
                    fire2 = r.pend && cond2;
                    if (fetch_now) begin
                        n.ad = dword;
                        n.trdy_n = 1'b0;
                    end
                end else if (!bus.irdy_n) begin
                    // last transfer seen: release ad, drive controls high
                    n.state = T_TURN;
                    n.ad_oe = 1'b0;
                    n.devsel_n = 1'b1;
                    n.trdy_n = 1'b1;
                end
            end
            T_TURN: begin
                // next cycle is idle: float controls, drop the hit
                n.ctl_oe = 1'b0;
                n.bar_hit = `PTS_BAR_HIT_RST;
                n.pend = 1'b0;
                n.state = T_IDLE;
            end
            default: begin
                n = TGT_RST;
            end
        endcase
        // second half: the other strobe of the same or next qword
        if (fire2) begin
            {n.lo_n, n.hi_n} = half_strobe(r.qw);
            n.pend = 1'b0;
        end
    end

    // state register, constant image under reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= TGT_RST;
        end else begin
            r <= n;
        end
    end

    // pci pins
    assign bus.ad_t = r.ad;
    assign bus.ad_t_oe = r.ad_oe;
    assign bus.trdy_n_t = r.trdy_n;
    assign bus.devsel_n_t = r.devsel_n;
    assign bus.tctl_oe = r.ctl_oe;
    // local bus
    assign bus.local_addr_out = r.addr;
    assign bus.bar_hit = r.bar_hit;
    assign bus.low_half_xfer_n = r.lo_n;
    assign bus.high_half_xfer_n = r.hi_n;
    // user side
    assign o_busy = r.state != T_IDLE;
    assign o_last_hit = r.last_hit;
endmodule
